// ===== core/acb_core.sv
// accumulator calculate, compare and conditional branch unit, apb slave
`timescale 1ns/10ps
`include "acb_defs.svh"
module acb_core
#(
  parameter int IN_W = 12,
  parameter int PC_W = 16
)
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [IN_W-1:0] input_port,
  input  wire logic            alarm_in,
  input  wire logic            deviation_in,
  input  wire logic            position_in,
  input  wire logic            timeout_in,
  output logic                 irq
);

  if (IN_W < 1 || IN_W > 32)
  begin : g_bad_in_w
    $error("IN_W must lie in 1..32");
  end
  if (PC_W < 1 || PC_W > 32)
  begin : g_bad_pc_w
    $error("PC_W must lie in 1..32");
  end

  // sum of the four bytes of a word, modulo 256
  function automatic logic [7:0] sum_bytes(input logic [31:0] w);
    sum_bytes = 8'(w[31:24] + w[23:16] + w[15:8] + w[7:0]);
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a <= `ACB_OFF_IRQ_MASK) && (a[1:0] == 2'b00);
  endfunction

  logic                 rst_meta_q;
  logic                 rst_b_sync;
  logic [IN_W+3:0]      pin_meta_q;
  logic [IN_W+3:0]      pin_sync_q;
  logic                 timeout_prev_q;
  acb_pkg::acb_state_e  state_q;
  acb_pkg::acb_state_e  state_d;
  acb_pkg::acb_cmd_s    cmd_q;
  acb_pkg::acb_cmd_s    cmd_d;
  acb_pkg::acb_flags_s  flags_q;
  acb_pkg::acb_flags_s  flags_d;
  logic [31:0]          val_q;
  logic [31:0]          val_d;
  logic [7:0]           cks_q;
  logic [7:0]           cks_d;
  logic [31:0]          acc_q;
  logic [31:0]          acc_d;
  logic [PC_W-1:0]      pc_q;
  logic [PC_W-1:0]      pc_d;
  logic                 mode_q;
  logic                 mode_d;
  logic [7:0]           reply_st_q;
  logic [7:0]           reply_st_d;
  logic [7:0]           reply_ck_q;
  logic [7:0]           reply_ck_d;
  logic [31:0]          reply_val_q;
  logic [31:0]          reply_val_d;
  logic [`ACB_IRQ_W-1:0] istat_q;
  logic [`ACB_IRQ_W-1:0] istat_d;
  logic [`ACB_IRQ_W-1:0] imask_q;
  logic [`ACB_IRQ_W-1:0] imask_d;
  logic [`ACB_IRQ_W-1:0] iset;
  logic [31:0]          prdata_q;
  logic [31:0]          prdata_d;
  logic                 wr_acc;
  logic                 clr_err_w;
  logic                 cks_ok;
  logic                 taken;
  logic [31:0]          rval;
  logic [7:0]           rst_code;
  logic [31:0]          in_word;
  logic                 ex_ok;

  // reset is released through two flops, asserted at once
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_q <= 1'b0;
      rst_b_sync <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_b_sync <= rst_meta_q;
    end
  end

  // pins come from outside the clock domain, two flops before any use
  always_ff @(posedge clk or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      pin_meta_q     <= '0;
      pin_sync_q     <= '0;
      timeout_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q     <= {timeout_in, position_in, deviation_in, alarm_in,
                         input_port};
      pin_sync_q     <= pin_meta_q;
      timeout_prev_q <= pin_sync_q[IN_W+3];
    end
  end

  // bus strobes; pready is fixed high, so every access ends in one cycle
  assign wr_acc    = psel && penable && pwrite;
  assign clr_err_w = wr_acc && (paddr == `ACB_OFF_CTRL)
                     && pwdata[`ACB_CTRL_CLR_ERR];
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && !addr_known(paddr);
  assign prdata    = prdata_q;
  assign irq       = |(istat_q & imask_q);
  assign in_word   = 32'(pin_sync_q[IN_W-1:0]);

  // frame check: target, instruction, type, bank and value bytes
  assign cks_ok = 8'(sum_bytes(cmd_q) + sum_bytes(val_q)) == cks_q;
  assign ex_ok  = (state_q == acb_pkg::acb_st_exec) && cks_ok;

  // condition of the jump from the flags of the latest compare or the sticky error flags
  always_comb
  begin
    case (acb_pkg::acb_cond_e'(cmd_q.kind))
      acb_pkg::acb_cond_zero:         taken = flags_q.zero;
      acb_pkg::acb_cond_nonzero:      taken = !flags_q.zero;
      acb_pkg::acb_cond_equal:        taken = flags_q.zero;
      acb_pkg::acb_cond_not_equal:    taken = !flags_q.zero;
      acb_pkg::acb_cond_greater:      taken = flags_q.greater;
      acb_pkg::acb_cond_greater_equal: taken = !flags_q.lower;
      acb_pkg::acb_cond_lower:        taken = flags_q.lower;
      acb_pkg::acb_cond_lower_equal:  taken = !flags_q.greater;
      acb_pkg::acb_cond_timeout_error_flag:
        taken = flags_q.timeout_error_flag;
      acb_pkg::acb_cond_external_alarm_flag:
        taken = flags_q.external_alarm_flag;
      acb_pkg::acb_cond_deviation_error_flag:
        taken = flags_q.deviation_error_flag;
      acb_pkg::acb_cond_position_error_flag:
        taken = flags_q.position_error_flag;
      default:                        taken = 1'b0;
    endcase
  end

  // bus writes, command execution, flags and interrupt status
  always_comb
  begin
    state_d     = state_q;
    cmd_d       = cmd_q;
    val_d       = val_q;
    cks_d       = cks_q;
    acc_d       = acc_q;
    pc_d        = pc_q;
    mode_d      = mode_q;
    flags_d     = flags_q;
    reply_st_d  = reply_st_q;
    reply_ck_d  = reply_ck_q;
    reply_val_d = reply_val_q;
    imask_d     = imask_q;
    iset        = '0;
    rval        = val_q;
    rst_code    = `ACB_ST_OK;
    if (wr_acc)
    begin
      case (paddr)
        `ACB_OFF_CTRL:     mode_d  = pwdata[`ACB_CTRL_STANDALONE];
        `ACB_OFF_CMD:      cmd_d   = acb_pkg::acb_cmd_s'(pwdata);
        `ACB_OFF_VALUE:    val_d   = pwdata;
        `ACB_OFF_PC:       pc_d    = pwdata[PC_W-1:0];
        `ACB_OFF_IRQ_MASK: imask_d = pwdata[`ACB_IRQ_W-1:0];
        `ACB_OFF_CKSUM:
        begin
          // a launch while busy is dropped, the frame already runs
          if (state_q == acb_pkg::acb_st_idle)
          begin
            cks_d   = pwdata[7:0];
            state_d = acb_pkg::acb_st_exec;
          end
        end
        default: ;
      endcase
    end
    case (state_q)
      acb_pkg::acb_st_idle: ;
      acb_pkg::acb_st_exec:
      begin
        state_d = acb_pkg::acb_st_idle;
        if (!cks_ok)
          rst_code = `ACB_ST_CKSUM;
        else
        begin
          case (cmd_q.instr)
            `ACB_INS_ARITH:
            begin
              // bank field not looked at; divide by zero keeps the acc
              case (acb_pkg::acb_arith_e'(cmd_q.kind))
                acb_pkg::acb_op_add:  acc_d = acc_q + val_q;
                acb_pkg::acb_op_sub:  acc_d = acc_q - val_q;
                acb_pkg::acb_op_mul:  acc_d = acc_q * val_q;
                acb_pkg::acb_op_div:
                  if (val_q != 32'h0000_0000)
                    acc_d = 32'($signed(acc_q) / $signed(val_q));
                acb_pkg::acb_op_modulo:
                  if (val_q != 32'h0000_0000)
                    acc_d = 32'($signed(acc_q) % $signed(val_q));
                acb_pkg::acb_op_and:  acc_d = acc_q & val_q;
                acb_pkg::acb_op_or:   acc_d = acc_q | val_q;
                acb_pkg::acb_op_xor:  acc_d = acc_q ^ val_q;
                acb_pkg::acb_op_not:  acc_d = ~acc_q;
                acb_pkg::acb_op_load: acc_d = val_q;
                default:              rst_code = `ACB_ST_BAD_TYPE;
              endcase
              rval = val_q;
            end
            `ACB_INS_COMPARE:
            begin
              flags_d.zero    = (acc_q - val_q) == 32'h0000_0000;
              flags_d.greater = $signed(acc_q) > $signed(val_q);
              flags_d.lower   = $signed(acc_q) < $signed(val_q);
            end
            `ACB_INS_COND_JUMP:
            begin
              if (cmd_q.kind > 8'h0b)
                rst_code = `ACB_ST_BAD_TYPE;
              else if (taken)
              begin
                pc_d    = val_q[PC_W-1:0];
                iset[`ACB_IRQ_JUMP] = 1'b1;
              end
            end
            `ACB_INS_INPUT_READ:
            begin
              rval = in_word;
              if (mode_q)
                acc_d = in_word;
            end
            default: rst_code = `ACB_ST_BAD_CMD;
          endcase
          // a stored program steps on unless the jump was taken
          if (mode_q && !(cmd_q.instr == `ACB_INS_COND_JUMP && taken
              && rst_code == `ACB_ST_OK))
            pc_d = PC_W'(pc_q + 1'b1); // wraps at the top of the counter
        end
        reply_st_d  = rst_code;
        reply_val_d = rval;
        reply_ck_d  = 8'(sum_bytes({`ACB_HOST_ADDR, cmd_q.target, rst_code,
                      cmd_q.instr}) + sum_bytes(rval));
        iset[`ACB_IRQ_DONE]  = 1'b1;
        iset[`ACB_IRQ_ERROR] = (rst_code != `ACB_ST_OK);
      end
      default: state_d = acb_pkg::acb_st_idle;
    endcase
    // error flags are sticky; a new event beats a clear in the same cycle
    if (clr_err_w)
    begin
      flags_d.timeout_error_flag   = 1'b0;
      flags_d.external_alarm_flag  = 1'b0;
      flags_d.deviation_error_flag = 1'b0;
      flags_d.position_error_flag  = 1'b0;
    end
    if (pin_sync_q[IN_W+3] && !timeout_prev_q)
      flags_d.timeout_error_flag = 1'b1;
    if (pin_sync_q[IN_W])
      flags_d.external_alarm_flag = 1'b1;
    if (pin_sync_q[IN_W+1])
      flags_d.deviation_error_flag = 1'b1;
    if (pin_sync_q[IN_W+2])
      flags_d.position_error_flag = 1'b1;
    // write one to clear, set wins
    istat_d = istat_q;
    if (wr_acc && paddr == `ACB_OFF_IRQ_STAT)
      istat_d = istat_q & ~pwdata[`ACB_IRQ_W-1:0];
    istat_d = istat_d | iset;
  end

  // read data is latched in the setup cycle and shown in the access cycle
  always_comb
  begin
    prdata_d = prdata_q;
    if (psel && !penable)
    begin
      case (paddr)
        `ACB_OFF_CTRL:      prdata_d = 32'(mode_q);
        `ACB_OFF_CMD:       prdata_d = cmd_q;
        `ACB_OFF_VALUE:     prdata_d = val_q;
        `ACB_OFF_CKSUM:     prdata_d = 32'(cks_q);
        `ACB_OFF_REPLY_ST:  prdata_d = {8'h00, reply_ck_q, cmd_q.instr,
                                        reply_st_q};
        `ACB_OFF_REPLY_VAL: prdata_d = reply_val_q;
        `ACB_OFF_ACC:       prdata_d = acc_q;
        `ACB_OFF_PC:        prdata_d = 32'(pc_q);
        `ACB_OFF_FLAGS:     prdata_d = {23'h000000,
                                        state_q == acb_pkg::acb_st_exec,
                                        1'b0, flags_q};
        `ACB_OFF_IRQ_STAT:  prdata_d = 32'(istat_q);
        `ACB_OFF_IRQ_MASK:  prdata_d = 32'(imask_q);
        default:            prdata_d = `ACB_RST_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b_sync)
  begin
    if (!rst_b_sync)
    begin
      state_q     <= acb_pkg::acb_st_idle;
      cmd_q       <= '0;
      val_q       <= `ACB_RST_WORD;
      cks_q       <= 8'h00;
      acc_q       <= `ACB_RST_WORD;
      pc_q        <= '0;
      mode_q      <= 1'b0;
      flags_q     <= '0;
      reply_st_q  <= 8'h00;
      reply_ck_q  <= 8'h00;
      reply_val_q <= `ACB_RST_WORD;
      istat_q     <= '0;
      imask_q     <= '0;
      prdata_q    <= `ACB_RST_WORD;
    end
    else
    begin
      state_q     <= state_d;
      cmd_q       <= cmd_d;
      val_q       <= val_d;
      cks_q       <= cks_d;
      acc_q       <= acc_d;
      pc_q        <= pc_d;
      mode_q      <= mode_d;
      flags_q     <= flags_d;
      reply_st_q  <= reply_st_d;
      reply_ck_q  <= reply_ck_d;
      reply_val_q <= reply_val_d;
      istat_q     <= istat_d;
      imask_q     <= imask_d;
      prdata_q    <= prdata_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b_sync);

  chk_arith_add: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind == 8'h00
    |=> acc_q == $past(acc_q) + $past(val_q))
    else $error("add result wrong");
  chk_arith_mul: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind == 8'h02
    |=> acc_q == 32'($past(acc_q) * $past(val_q)))
    else $error("multiply result wrong");
  chk_logic_xor: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind == 8'h07
    |=> acc_q == ($past(acc_q) ^ $past(val_q)))
    else $error("xor result wrong");
  chk_arith_not: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind == 8'h08
    |=> acc_q == ~$past(acc_q))
    else $error("invert result wrong");
  chk_arith_load: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind == 8'h09
    |=> acc_q == $past(val_q))
    else $error("load result wrong");
  chk_reply_ok: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_ARITH && cmd_q.kind <= 8'h09
    |=> reply_st_q == `ACB_ST_OK && reply_val_q == $past(val_q))
    else $error("arithmetic reply wrong");
  chk_comp_signed: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_COMPARE
    |=> $stable(acc_q) && flags_q.zero == ($past(acc_q) == $past(val_q))
        && flags_q.lower == ($signed($past(acc_q)) < $signed($past(val_q))))
    else $error("compare flags wrong");
  chk_flags_held: assert property (
    !(ex_ok && cmd_q.instr == `ACB_INS_COMPARE)
    |=> $stable({flags_q.zero, flags_q.greater, flags_q.lower}))
    else $error("compare flags moved");
  chk_jump_not_lower: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_COND_JUMP && cmd_q.kind == 8'h05
    |=> pc_q == (!$past(flags_q.lower) ? $past(val_q[PC_W-1:0])
        : $past(pc_q) + PC_W'($past(mode_q))))
    else $error("conditional jump wrong");
  chk_jump_timeout: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_COND_JUMP && cmd_q.kind == 8'h08
    && flags_q.timeout_error_flag |=> pc_q == PC_W'($past(val_q)))
    else $error("timeout jump not taken");
  chk_input_direct: assert property (
    ex_ok && cmd_q.instr == `ACB_INS_INPUT_READ && !mode_q
    |=> $stable(acc_q) ##0 reply_val_q == $past(in_word))
    else $error("direct input read touched acc");
  chk_timeout_sticky: assert property (
    flags_q.timeout_error_flag && !clr_err_w |=> flags_q.timeout_error_flag)
    else $error("timeout flag lost");
  chk_cksum_reject: assert property (
    state_q == acb_pkg::acb_st_exec && !cks_ok
    |=> $stable(acc_q) && reply_st_q == `ACB_ST_CKSUM)
    else $error("bad checksum not refused");

  cov_jump_taken: cover property (ex_ok
    && cmd_q.instr == `ACB_INS_COND_JUMP && taken);
  cov_divide: cover property (ex_ok && cmd_q.instr == `ACB_INS_ARITH
    && cmd_q.kind == 8'h03);
  cov_cksum_bad: cover property (state_q == acb_pkg::acb_st_exec && !cks_ok);

endmodule

// ===== core/acb_defs.svh
// register offsets, field positions, reset values and codes of the block
`ifndef ACB_DEFS_SVH
`define ACB_DEFS_SVH
`define ACB_OFF_CTRL      8'h00
`define ACB_OFF_CMD       8'h04
`define ACB_OFF_VALUE     8'h08
`define ACB_OFF_CKSUM     8'h0c
`define ACB_OFF_REPLY_ST  8'h10
`define ACB_OFF_REPLY_VAL 8'h14
`define ACB_OFF_ACC       8'h18
`define ACB_OFF_PC        8'h1c
`define ACB_OFF_FLAGS     8'h20
`define ACB_OFF_IRQ_STAT  8'h24
`define ACB_OFF_IRQ_MASK  8'h28
`define ACB_CTRL_STANDALONE 0
`define ACB_CTRL_CLR_ERR    1
`define ACB_FLAGS_BUSY      8
`define ACB_IRQ_DONE  0
`define ACB_IRQ_ERROR 1
`define ACB_IRQ_JUMP  2
`define ACB_IRQ_W     3
`define ACB_INS_INPUT_READ 8'h0f
`define ACB_INS_ARITH      8'h13
`define ACB_INS_COMPARE    8'h14
`define ACB_INS_COND_JUMP  8'h15
`define ACB_ST_OK       8'h64
`define ACB_ST_CKSUM    8'h01
`define ACB_ST_BAD_CMD  8'h02
`define ACB_ST_BAD_TYPE 8'h03
`define ACB_HOST_ADDR   8'h02
`define ACB_RST_WORD    32'h0000_0000
`endif

// ===== core/acb_pkg.sv
// types shared by the accumulator calculate, compare and branch block
package acb_pkg;
  typedef enum logic [7:0] {
    acb_op_add = 8'h00, acb_op_sub = 8'h01, acb_op_mul = 8'h02,
    acb_op_div = 8'h03, acb_op_modulo = 8'h04, acb_op_and = 8'h05,
    acb_op_or = 8'h06, acb_op_xor = 8'h07, acb_op_not = 8'h08,
    acb_op_load = 8'h09
  } acb_arith_e;
  typedef enum logic [7:0] {
    acb_cond_zero = 8'h00, acb_cond_nonzero = 8'h01,
    acb_cond_equal = 8'h02, acb_cond_not_equal = 8'h03,
    acb_cond_greater = 8'h04, acb_cond_greater_equal = 8'h05,
    acb_cond_lower = 8'h06, acb_cond_lower_equal = 8'h07,
    acb_cond_timeout_error_flag = 8'h08,
    acb_cond_external_alarm_flag = 8'h09,
    acb_cond_deviation_error_flag = 8'h0a,
    acb_cond_position_error_flag = 8'h0b
  } acb_cond_e;
  typedef enum logic [1:0] {
    acb_st_idle = 2'b01,
    acb_st_exec = 2'b10
  } acb_state_e;
  // command word: target address, bank, type, instruction number
  typedef struct packed {
    logic [7:0] target;
    logic [7:0] bank;
    logic [7:0] kind;
    logic [7:0] instr;
  } acb_cmd_s;
  typedef struct packed {
    logic position_error_flag;
    logic deviation_error_flag;
    logic external_alarm_flag;
    logic timeout_error_flag;
    logic lower;
    logic greater;
    logic zero;
  } acb_flags_s;
endpackage

// ===== dv/acb_host.sv
// host model: apb master that frames and sends commands to the block
`timescale 1ns/10ps
`include "acb_defs.svh"
module acb_host
(
  input  wire logic        clk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic err_q;
  // bus idle from time zero
  initial
  begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    err_q = 1'h0;
  end
  // one transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    // no wait count assumed; only the bench watchdog ends a stuck wait
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'h1);
    q = prdata;
    err_q = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // a spare idle cycle keeps every transfer self-contained
    @(posedge clk);
  endtask
  // command, operand, then checksum; bad corrupts the checksum on purpose
  task automatic send(input logic [7:0] ins, input logic [7:0] typ,
                      input logic [7:0] bank, input logic [31:0] val,
                      input logic bad);
    logic [31:0] q;
    logic [7:0]  ck;
    ck = 8'h01 + ins + typ + bank + val[31:24] + val[23:16] + val[15:8]
         + val[7:0] + {7'h00, bad};
    xfer(1'h1, `ACB_OFF_CMD, {8'h01, bank, typ, ins}, q);
    xfer(1'h1, `ACB_OFF_VALUE, val, q);
    xfer(1'h1, `ACB_OFF_CKSUM, {24'h00_0000, ck}, q);
    // results land one edge after the checksum write edge
    @(posedge clk);
  endtask
endmodule

// ===== dv/test_accumulator_accumulator_arith_cmd_compare_branch.sv
// self-checking bench of the calculate, compare and branch block
`timescale 1ns/10ps
`include "acb_defs.svh"
module test_accumulator_accumulator_arith_cmd_compare_branch;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [11:0] input_port;
  logic [3:0]  ev;
  int          mismatches, compares;
  acb_core acb_core_i (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .input_port(input_port), .alarm_in(ev[1]), .deviation_in(ev[2]),
    .position_in(ev[3]), .timeout_in(ev[0]), .irq(irq));
  acb_host acb_host_i (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // 100 ns period
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    acb_host_i.xfer(1'h1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    acb_host_i.xfer(1'h0, a, 32'h0000_0000, q);
  endtask
  // signed divide and modulo follow the two's complement operand
  function automatic logic [31:0] arith_ref(input logic [7:0] t,
                                            input logic [31:0] a, b);
    case (t)
      8'h00: arith_ref = a + b;
      8'h01: arith_ref = a - b;
      8'h02: arith_ref = a * b;
      8'h03: arith_ref = $signed(a) / $signed(b);
      8'h04: arith_ref = $signed(a) % $signed(b);
      8'h05: arith_ref = a & b;
      8'h06: arith_ref = a | b;
      8'h07: arith_ref = a ^ b;
      8'h08: arith_ref = ~a;
      default: arith_ref = b;
    endcase
  endfunction
  function automatic logic taken(input logic [7:0] c,
                                 input logic [31:0] a, b);
    logic same, above;
    same = (a == b);
    above = $signed(a) > $signed(b);
    case (c)
      8'h00, 8'h02: taken = same;
      8'h01, 8'h03: taken = !same;
      8'h04: taken = above;
      8'h05: taken = above || same;
      8'h06: taken = !above && !same;
      default: taken = !above;
    endcase
  endfunction
  task automatic jmp(input logic [7:0] c, input logic tk);
    logic [31:0] v;
    logic [31:0] e;
    wr(`ACB_OFF_PC, 32'h0000_0010);
    acb_host_i.send(`ACB_INS_COND_JUMP, c, 8'h00, 32'h0000_0055, 1'h0);
    rd(`ACB_OFF_PC, v);
    e = tk ? 32'h0000_0055 : 32'h0000_0011;
    chk(v & 32'h0000_ffff, e, "pc");
  endtask
  // every operation type, bank field nonzero to show it is ignored
  task automatic t_arith();
    logic [31:0] v;
    logic [31:0] e;
    for (int t = 0; t < 10; t++)
    begin
      acb_host_i.send(`ACB_INS_ARITH, 8'h09, 8'h00, 32'hffff_fff9, 1'h0);
      acb_host_i.send(`ACB_INS_ARITH, t[7:0], 8'h5a, 32'h0000_0003, 1'h0);
      rd(`ACB_OFF_ACC, v);
      e = arith_ref(t[7:0], 32'hffff_fff9, 32'h0000_0003);
      chk(v, e, "acc");
      rd(`ACB_OFF_REPLY_ST, v);
      // reply checksum: host, target, status, instruction and value bytes
      e = {8'h00, 8'(8'h02 + 8'h01 + `ACB_ST_OK + `ACB_INS_ARITH + 8'h03),
           `ACB_INS_ARITH, `ACB_ST_OK};
      chk(v, e, "st");
      rd(`ACB_OFF_REPLY_VAL, v);
      chk(v, 32'h0000_0003, "reply");
    end
    $display("end t_arith");
  endtask
  // compare against smaller-signed, equal and larger, then the eight compare conditions
  task automatic t_cmp_jump();
    logic [31:0] ops [3];
    logic [31:0] v;
    logic        tk;
    ops = '{32'hffff_fffb, 32'h0000_0005, 32'h0000_0006};
    wr(`ACB_OFF_CTRL, 32'h0000_0001);
    for (int i = 0; i < 3; i++)
    begin
      acb_host_i.send(`ACB_INS_ARITH, 8'h09, 8'h00, 32'h0000_0005, 1'h0);
      acb_host_i.send(`ACB_INS_COMPARE, 8'h33, 8'h44, ops[i], 1'h0);
      rd(`ACB_OFF_ACC, v);
      chk(v, 32'h0000_0005, "acc kept");
      for (int c = 0; c < 8; c++)
      begin
        tk = taken(c[7:0], 32'h0000_0005, ops[i]);
        jmp(c[7:0], tk);
      end
    end
    $display("end t_cmp_jump");
  endtask
  // each error input alone, then cleared
  task automatic t_err();
    for (int i = 0; i < 4; i++)
    begin
      ev[i] <= 1'h1;
      repeat (3) @(posedge clk);
      ev[i] <= 1'h0;
      repeat (4) @(posedge clk);
      for (int c = 0; c < 4; c++)
        jmp(8'h08 + c[7:0], c == i);
      wr(`ACB_OFF_CTRL, 32'h0000_0003);
      jmp(8'h08 + i[7:0], 1'h0);
    end
    $display("end t_err");
  endtask
  // input read reaches the accumulator only in standalone mode
  task automatic t_input();
    logic [31:0] v;
    input_port <= 12'h12e;
    wr(`ACB_OFF_CTRL, 32'h0000_0000);
    acb_host_i.send(`ACB_INS_ARITH, 8'h09, 8'h00, 32'h0000_0007, 1'h0);
    acb_host_i.send(`ACB_INS_INPUT_READ, 8'h00, 8'h01, 32'h0000_0000, 1'h0);
    rd(`ACB_OFF_REPLY_VAL, v);
    chk(v, 32'h0000_012e, "in reply");
    rd(`ACB_OFF_ACC, v);
    chk(v, 32'h0000_0007, "acc direct");
    wr(`ACB_OFF_CTRL, 32'h0000_0001);
    acb_host_i.send(`ACB_INS_INPUT_READ, 8'h00, 8'h01, 32'h0000_0000, 1'h0);
    rd(`ACB_OFF_ACC, v);
    chk(v, 32'h0000_012e, "acc standalone");
    $display("end t_input");
  endtask
  // bad checksum executes nothing; error interrupt masked and cleared
  task automatic t_cksum_irq();
    logic [31:0] v;
    wr(`ACB_OFF_IRQ_STAT, 32'h0000_0007);
    wr(`ACB_OFF_IRQ_MASK, 32'h0000_0002);
    acb_host_i.send(`ACB_INS_ARITH, 8'h09, 8'h00, 32'h0000_0099, 1'h1);
    rd(`ACB_OFF_REPLY_ST, v);
    chk(v & 32'h0000_00ff, {24'h00_0000, `ACB_ST_CKSUM}, "st");
    rd(`ACB_OFF_ACC, v);
    chk(v, 32'h0000_012e, "acc");
    chk({31'h0, irq}, 32'h0000_0001, "irq on");
    wr(`ACB_OFF_IRQ_MASK, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000, "irq masked");
    wr(`ACB_OFF_IRQ_MASK, 32'h0000_0002);
    wr(`ACB_OFF_IRQ_STAT, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000, "irq cleared");
    // refused instruction and types: status codes, acc left alone
    acb_host_i.send(8'h00, 8'h00, 8'h00, 32'h0000_0000, 1'h0);
    rd(`ACB_OFF_REPLY_ST, v);
    chk(v & 32'h0000_00ff, {24'h00_0000, `ACB_ST_BAD_CMD}, "st cmd");
    acb_host_i.send(`ACB_INS_ARITH, 8'h0a, 8'h00, 32'h0000_0044, 1'h0);
    rd(`ACB_OFF_REPLY_ST, v);
    chk(v & 32'h0000_00ff, {24'h00_0000, `ACB_ST_BAD_TYPE}, "st arith");
    rd(`ACB_OFF_ACC, v);
    chk(v, 32'h0000_012e, "acc bad type");
    acb_host_i.send(`ACB_INS_COND_JUMP, 8'h0c, 8'h00, 32'h0000_0000, 1'h0);
    rd(`ACB_OFF_REPLY_ST, v);
    chk(v & 32'h0000_00ff, {24'h00_0000, `ACB_ST_BAD_TYPE}, "st jump");
    rd(`ACB_OFF_IRQ_STAT, v);
    chk(v, 32'h0000_0003, "irq stat");
    chk({31'h0, irq}, 32'h0000_0001, "irq error");
    // equal compare then a taken zero jump raises the jump event
    wr(`ACB_OFF_IRQ_STAT, 32'h0000_0007);
    acb_host_i.send(`ACB_INS_COMPARE, 8'h00, 8'h00, 32'h0000_012e, 1'h0);
    acb_host_i.send(`ACB_INS_COND_JUMP, 8'h00, 8'h00, 32'h0000_0021, 1'h0);
    rd(`ACB_OFF_IRQ_STAT, v);
    chk(v, 32'h0000_0005, "irq jump");
    chk({31'h0, irq}, 32'h0000_0000, "irq jump masked");
    rd(8'h2c, v);
    chk({v[30:0], acb_host_i.err_q}, 32'h0000_0001, "unmapped");
    $display("end t_cksum_irq");
  endtask
  // watchdog: the run needs about 1300 cycles
  initial
  begin
    #3_000_000;
    mismatches++;
    give_verdict();
  end
  initial
  begin
    mismatches = 0;
    compares = 0;
    rst_b = 1'h0;
    input_port = 12'h000;
    ev = 4'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    t_arith();
    t_cmp_jump();
    t_err();
    t_input();
    t_cksum_irq();
    give_verdict();
  end
endmodule
